// [iss_core.sv]
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
// Instruction sequencer: phases, program counter, flow and registers
// What this block does
// RULE1 - Four non-overlapping phases from the clock form one instruction cycle.
// RULE2 - Program counter advances and fetch happens at start of phase one.
// RULE3 - Next fetch overlaps current execution; one instruction per cycle.
// RULE4 - Jumps and calls take two instruction cycles.
// RULE5 - Sequential instructions increase program counter by exactly one.
// RULE6 - Counter is 12 bits, 4 upper plus 8 lower; only low byte visible. The bus port also reads all 12 bits at ISS_OFF_PC.
// RULE7 - Jump, call, interrupt and reset load the target into the counter.
// RULE8 - Taken skip discards fetched instruction, inserting a dummy cycle.
// RULE9 - Writing the low byte jumps within the page with a dummy cycle.
// RULE10 - Low byte is readable and writable as an ordinary register.
// RULE11 - Four-entry return stack, not software visible.
// RULE12 - Call or acknowledged interrupt pushes the program counter.
// RULE13 - Returns restore the counter from the top stack entry.
// RULE14 - Reset points the stack pointer at the stack top.
// RULE15 - Interrupt with full stack is held until a return frees a level.
// RULE16 - Call with full stack still executes, losing the oldest entry.
// RULE17 - 8-bit unit works through accumulator, result to chosen target.
// RULE18 - Status flags update on carry, borrow and other changes.
// RULE19 - Add, subtract, decimal adjust, logic, rotate, inc and dec.
// RULE20 - Reset loads program counter with address zero.
// RULE21 - Low-byte writes keep the four upper counter bits.
module iss_core
   import iss_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Program memory fetch
   output logic [11:0] fetch_addr_out,
   output logic fetch_strobe_out,
   input wire logic [15:0] fetch_word_in,
   // Decoded instruction presented by the decoder
   input wire iss_flow_t flow_op_in,
   input wire logic [11:0] flow_target_in,
   input wire logic skip_cond_in,
   input wire logic ret_from_int_in,
   input wire iss_alop_t alu_op_in,
   input wire logic [7:0] alu_operand_in,
   input wire logic alu_to_mem_in,
   // Interrupt request, already synchronous
   input wire logic int_req_in,
   input wire logic [11:0] int_vector_in,
   output logic int_ack_out,
   // Status of the sequencer
   output logic [15:0] instr_out,
   output logic [3:0] phase_out,
   output logic dummy_out,
   output logic [7:0] mem_result_out,
   output logic mem_write_out,
   output logic [3:0] status_out,
   output logic [7:0] acc_out,
   output logic [2:0] stack_level_out
);
   typedef struct packed {
      iss_phase_t phase;
      logic [11:0] pc;
      logic [15:0] instr;
      logic dummy;
      logic int_pend;
      logic int_ack;
      logic [7:0] acc;
      logic [3:0] status;
      logic [7:0] mem_res;
      logic mem_wr;
      logic pcl_wr_pend;
      logic [7:0] pcl_wr_val;
      logic ack;
      logic [31:0] rdata;
   } iss_core_state_t;
   iss_core_state_t s_q, s_d;

   iss_alu_if alu_bus ();
   logic stack_push, stack_pop, stack_full;
   logic [11:0] stack_top, push_addr;

   iss_alu u_alu (
      .bus(alu_bus.alu)
   );

   iss_stack u_stack (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .push_in(stack_push),
      .pop_in(stack_pop),
      .push_addr_in(push_addr),
      .top_addr_out(stack_top),
      .full_out(stack_full),
      .level_out(stack_level_out)
   );

   // Sequential successor of an address
   function automatic logic [11:0] iss_next(input logic [11:0] a);
      return a + 12'h001;
   endfunction

   // Register decode for a bus access
   function automatic logic iss_hit(input logic [3:0] adr,
         input logic [3:0] off);
      return adr == off;
   endfunction

   logic exec_edge;
   logic bus_req;
   logic [7:0] pcl_wdata;

   // Execution completes at end of phase four
   assign exec_edge = (s_q.phase == ISS_PH4); // [RULE1]
   assign bus_req = (avs_read_in | avs_write_in) & ~s_q.ack;
   assign pcl_wdata = avs_writedata_in[7:0];

   // Operands into the arithmetic unit
   assign alu_bus.op = s_q.dummy ? ISS_AL_NONE : alu_op_in;
   assign alu_bus.a = s_q.acc;
   assign alu_bus.b = alu_operand_in;
   assign alu_bus.status = s_q.status;

   // Stack control during the execute edge
   always_comb begin
      stack_push = 1'b0;
      stack_pop = 1'b0;
      push_addr = s_q.pc;
      // A pending low-byte write wins, so nothing is pushed or popped then
      if (exec_edge && !s_q.pcl_wr_pend) begin
         if (!s_q.dummy && flow_op_in == ISS_FL_CALL) begin
            stack_push = 1'b1; // [RULE12] [RULE16]
         end else if (!s_q.dummy && flow_op_in == ISS_FL_RET) begin
            stack_pop = 1'b1; // [RULE13]
         end else if (s_q.int_pend && !stack_full
               && !(!s_q.dummy && flow_op_in == ISS_FL_JUMP)) begin
            stack_push = 1'b1; // [RULE12] [RULE15]
         end
      end
   end

   // Next state of the sequencer
   always_comb begin
      s_d = s_q;
      s_d.mem_wr = 1'b0;
      s_d.int_ack = 1'b0;
      s_d.ack = 1'b0;
      // Phase rotation, one step per clock
      unique case (s_q.phase)
         ISS_PH1: s_d.phase = ISS_PH2; // [RULE1]
         ISS_PH2: s_d.phase = ISS_PH3;
         ISS_PH3: s_d.phase = ISS_PH4;
         ISS_PH4: s_d.phase = ISS_PH1;
      endcase
      // Interrupt flag recorded even while stack full
      if (int_req_in) s_d.int_pend = 1'b1; // [RULE15]
      // Fetch latch at end of phase one, overlapping execution
      if (s_q.phase == ISS_PH1)
         s_d.instr = fetch_word_in; // [RULE3] [RULE2]

      // Bus slave: one wait cycle, read data ready for the second edge
      if (bus_req) begin
         s_d.ack = 1'b1;
         s_d.rdata = 32'h0000_0000;
         if (iss_hit(avs_address_in, ISS_OFF_PCL))
            s_d.rdata = {24'h000000, s_q.pc[7:0]}; // [RULE10]
         else if (iss_hit(avs_address_in, ISS_OFF_PC))
            s_d.rdata = {20'h00000, s_q.pc};
         else if (iss_hit(avs_address_in, ISS_OFF_ACC))
            s_d.rdata = {24'h000000, s_q.acc};
         else if (iss_hit(avs_address_in, ISS_OFF_STATUS))
            s_d.rdata = {28'h0000000, s_q.status};
      end
      // Writes land only at the edge where waitrequest is low
      if (avs_write_in && s_q.ack && avs_byteenable_in[0]) begin
         if (iss_hit(avs_address_in, ISS_OFF_PCL)) begin
            s_d.pcl_wr_pend = 1'b1; // [RULE9] [RULE10]
            s_d.pcl_wr_val = pcl_wdata;
         end else if (iss_hit(avs_address_in, ISS_OFF_ACC)) begin
            s_d.acc = avs_writedata_in[7:0];
         end else if (iss_hit(avs_address_in, ISS_OFF_STATUS)) begin
            s_d.status = avs_writedata_in[3:0];
         end
      end

      // Execute edge: retire current word, start next fetch at phase one
      if (exec_edge) begin
         s_d.dummy = 1'b0;
         if (!s_q.dummy && alu_op_in != ISS_AL_NONE) begin
            if (alu_to_mem_in) begin
               s_d.mem_res = alu_bus.result; // [RULE17]
               s_d.mem_wr = 1'b1;
            end else begin
               s_d.acc = alu_bus.result; // [RULE17] [RULE19]
            end
            if (alu_bus.writes_flags)
               s_d.status = alu_bus.status_new; // [RULE18]
         end
         if (s_q.pcl_wr_pend) begin
            // Page kept, low byte replaced, prefetch discarded
            s_d.pc = {s_q.pc[11:8], s_q.pcl_wr_val}; // [RULE9] [RULE21]
            s_d.pcl_wr_pend = 1'b0;
            s_d.dummy = 1'b1;
         end else if (!s_q.dummy && (flow_op_in == ISS_FL_JUMP
               || flow_op_in == ISS_FL_CALL)) begin
            s_d.pc = flow_target_in; // [RULE7] [RULE4]
            s_d.dummy = 1'b1;
         end else if (!s_q.dummy && flow_op_in == ISS_FL_RET) begin
            s_d.pc = stack_top; // [RULE13]
            s_d.dummy = 1'b1;
            if (ret_from_int_in) s_d.int_pend = s_d.int_pend;
         end else if (s_q.int_pend && !stack_full) begin
            s_d.pc = int_vector_in; // [RULE7] [RULE15]
            s_d.int_pend = int_req_in;
            s_d.int_ack = 1'b1;
            s_d.dummy = 1'b1;
         end else if (!s_q.dummy && flow_op_in == ISS_FL_SKIP
               && skip_cond_in) begin
            s_d.pc = iss_next(s_q.pc); // [RULE8]
            s_d.dummy = 1'b1;
         end else begin
            s_d.pc = iss_next(s_q.pc); // [RULE5] [RULE2]
         end
      end
   end

   // State register; reset sits in a dummy cycle fetching address zero
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_q.phase <= ISS_PH1;
         s_q.pc <= ISS_RESET_VECTOR; // [RULE20] [RULE7]
         s_q.instr <= 16'h0000;
         s_q.dummy <= 1'b1;
         s_q.int_pend <= 1'b0;
         s_q.int_ack <= 1'b0;
         s_q.acc <= ISS_ACC_RESET;
         s_q.status <= ISS_STATUS_RESET;
         s_q.mem_res <= 8'h00;
         s_q.mem_wr <= 1'b0;
         s_q.pcl_wr_pend <= 1'b0;
         s_q.pcl_wr_val <= 8'h00;
         s_q.ack <= 1'b0;
         s_q.rdata <= 32'h0000_0000;
      end else begin
         s_q <= s_d;
      end
   end

   // Fetch address is the counter during phase one
   assign fetch_addr_out = s_q.pc; // [RULE6]
   assign fetch_strobe_out = (s_q.phase == ISS_PH1);
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~s_q.ack;
   assign avs_readdata_out = s_q.rdata;
   assign instr_out = s_q.instr;
   assign phase_out = s_q.phase;
   assign dummy_out = s_q.dummy;
   assign mem_result_out = s_q.mem_res;
   assign mem_write_out = s_q.mem_wr;
   assign status_out = s_q.status;
   assign acc_out = s_q.acc;
   assign int_ack_out = s_q.int_ack;
endmodule

// [iss_pkg.sv]
// Shared constants and types for the instruction sequencer
package iss_pkg;
   localparam int ISS_PC_W = 12;
   localparam int ISS_PCH_W = 4;
   localparam int ISS_DW = 8;
   localparam int ISS_STACK_DEPTH = 4;
   localparam int ISS_SP_W = 3;
   localparam logic [11:0] ISS_RESET_VECTOR = 12'h000;
   localparam logic [2:0] ISS_SP_RESET = 3'h0;
   // Register offsets (word aligned byte addresses)
   localparam logic [3:0] ISS_OFF_PCL = 4'h0;
   localparam logic [3:0] ISS_OFF_PC = 4'h4;
   localparam logic [3:0] ISS_OFF_ACC = 4'h8;
   localparam logic [3:0] ISS_OFF_STATUS = 4'hc;
   // Status flag positions
   localparam int ISS_ST_C = 0;
   localparam int ISS_ST_AC = 1;
   localparam int ISS_ST_Z = 2;
   localparam int ISS_ST_OV = 3;
   localparam logic [3:0] ISS_STATUS_RESET = 4'h0;
   localparam logic [7:0] ISS_ACC_RESET = 8'h00;
   // Instruction phases, one-hot
   typedef enum logic [3:0] {
      ISS_PH1 = 4'b0001,
      ISS_PH2 = 4'b0010,
      ISS_PH3 = 4'b0100,
      ISS_PH4 = 4'b1000
   } iss_phase_t;
   // Flow operations presented with each instruction
   typedef enum logic [2:0] {
      ISS_FL_SEQ = 3'h0,
      ISS_FL_JUMP = 3'h1,
      ISS_FL_CALL = 3'h2,
      ISS_FL_RET = 3'h3,
      ISS_FL_SKIP = 3'h4
   } iss_flow_t;
   // Arithmetic/logic operations
   typedef enum logic [3:0] {
      ISS_AL_NONE = 4'h0, ISS_AL_ADD = 4'h1, ISS_AL_ADC = 4'h2,
      ISS_AL_SUB = 4'h3, ISS_AL_SBC = 4'h4, ISS_AL_DAA = 4'h5,
      ISS_AL_AND = 4'h6, ISS_AL_OR = 4'h7, ISS_AL_XOR = 4'h8,
      ISS_AL_CPL = 4'h9, ISS_AL_RR = 4'ha, ISS_AL_RRC = 4'hb,
      ISS_AL_RL = 4'hc, ISS_AL_RLC = 4'hd, ISS_AL_INC = 4'he,
      ISS_AL_DEC = 4'hf
   } iss_alop_t;
endpackage

// [iss_alu_if.sv]
`timescale 1ns/10ps
// Interface joining the sequencer to its arithmetic unit
interface iss_alu_if;
   import iss_pkg::*;
   iss_alop_t op;
   logic [7:0] a;
   logic [7:0] b;
   logic [3:0] status;
   logic [7:0] result;
   logic [3:0] status_new;
   logic writes_flags;
   modport core (output op, a, b, status,
      input result, status_new, writes_flags);
   modport alu (input op, a, b, status,
      output result, status_new, writes_flags);
endinterface

// [iss_alu.sv]
`timescale 1ns/10ps
// Eight-bit arithmetic and logic unit with flag generation
module iss_alu
   import iss_pkg::*;
(
   iss_alu_if.alu bus
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] adj;
   // Result and flags for the selected operation
   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      adj = 8'h00;
      bus.result = bus.a;
      bus.status_new = bus.status;
      bus.writes_flags = 1'b1;
      unique case (bus.op)
         ISS_AL_ADD, ISS_AL_ADC: begin
            sum = {1'b0, bus.a} + {1'b0, bus.b}
               + {8'h00, bus.op == ISS_AL_ADC && bus.status[ISS_ST_C]};
            nib = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]}
               + {4'h0, bus.op == ISS_AL_ADC && bus.status[ISS_ST_C]};
            bus.result = sum[7:0];
            bus.status_new[ISS_ST_C] = sum[8];
            bus.status_new[ISS_ST_AC] = nib[4];
            bus.status_new[ISS_ST_OV] = (bus.a[7] == bus.b[7])
               && (sum[7] != bus.a[7]);
         end
         ISS_AL_SUB, ISS_AL_SBC: begin
            // Carry set means no borrow
            sum = {1'b0, bus.a} + {1'b0, ~bus.b}
               + {8'h00, bus.op == ISS_AL_SUB || bus.status[ISS_ST_C]};
            nib = {1'b0, bus.a[3:0]} + {1'b0, ~bus.b[3:0]}
               + {4'h0, bus.op == ISS_AL_SUB || bus.status[ISS_ST_C]};
            bus.result = sum[7:0];
            bus.status_new[ISS_ST_C] = sum[8];
            bus.status_new[ISS_ST_AC] = nib[4];
            bus.status_new[ISS_ST_OV] = (bus.a[7] != bus.b[7])
               && (sum[7] != bus.a[7]);
         end
         ISS_AL_DAA: begin
            adj = 8'h00;
            if (bus.a[3:0] > 4'h9 || bus.status[ISS_ST_AC]) adj[3:0] = 4'h6;
            if (bus.a > 8'h99 || bus.status[ISS_ST_C]) adj[7:4] = 4'h6;
            sum = {1'b0, bus.a} + {1'b0, adj};
            bus.result = sum[7:0];
            bus.status_new[ISS_ST_C] = sum[8] | bus.status[ISS_ST_C];
         end
         ISS_AL_AND: bus.result = bus.a & bus.b;
         ISS_AL_OR: bus.result = bus.a | bus.b;
         ISS_AL_XOR: bus.result = bus.a ^ bus.b;
         ISS_AL_CPL: bus.result = ~bus.a;
         ISS_AL_RR: begin
            bus.result = {bus.a[0], bus.a[7:1]};
            bus.writes_flags = 1'b0;
         end
         ISS_AL_RL: begin
            bus.result = {bus.a[6:0], bus.a[7]};
            bus.writes_flags = 1'b0;
         end
         ISS_AL_RRC: begin
            bus.result = {bus.status[ISS_ST_C], bus.a[7:1]};
            bus.status_new[ISS_ST_C] = bus.a[0];
         end
         ISS_AL_RLC: begin
            bus.result = {bus.a[6:0], bus.status[ISS_ST_C]};
            bus.status_new[ISS_ST_C] = bus.a[7];
         end
         ISS_AL_INC: bus.result = bus.a + 8'h01;
         ISS_AL_DEC: bus.result = bus.a - 8'h01;
         ISS_AL_NONE: bus.writes_flags = 1'b0;
      endcase
      // Zero flag on everything but rotates and idle
      if (bus.writes_flags && bus.op != ISS_AL_RRC && bus.op != ISS_AL_RLC)
         bus.status_new[ISS_ST_Z] = (bus.result == 8'h00);
   end
endmodule

// [iss_stack.sv]
`timescale 1ns/10ps
// Four-level return-address stack with pointer
module iss_stack
   import iss_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [11:0] push_addr_in,
   output logic [11:0] top_addr_out,
   output logic full_out,
   output logic [2:0] level_out
);
   typedef struct packed {
      logic [3:0][11:0] mem;
      logic [2:0] count;
   } iss_stack_state_t;
   iss_stack_state_t s_q, s_d;

   // Push shifts entries down; oldest drops when full
   always_comb begin
      s_d = s_q;
      if (push_in) begin
         s_d.mem = {s_q.mem[2:0], push_addr_in}; // [RULE12] [RULE16]
         if (s_q.count != 3'(ISS_STACK_DEPTH)) s_d.count = s_q.count + 3'h1;
      end else if (pop_in) begin
         s_d.mem = {12'h000, s_q.mem[3:1]}; // [RULE13]
         if (s_q.count != 3'h0) s_d.count = s_q.count - 3'h1;
      end
   end

   // State register; pointer starts at top of stack
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_q <= '0; // [RULE14]
      end else begin
         s_q <= s_d;
      end
   end

   assign top_addr_out = s_q.mem[0];
   assign full_out = (s_q.count == 3'(ISS_STACK_DEPTH)); // [RULE11]
   assign level_out = s_q.count;
endmodule

// [iss_prog_mem.sv]
// Program memory model answering the sequencer's fetches
`timescale 1ns/10ps
module iss_prog_mem (
   input wire logic clk_in,
   input wire logic strobe_in,
   input wire logic [11:0] addr_in,
   output logic [15:0] word_out
);
   logic [15:0] last_q;
   initial last_q = 16'h0000;
   // Remember the last word handed out
   always @(posedge clk_in) begin
      if (strobe_in) last_q <= {4'ha, addr_in};
   end
   // Tag nibble over the address; inverse of last word when not selected
   assign word_out = strobe_in ? {4'ha, addr_in} : ~last_q;
endmodule

// [iss_core_props.sv]
// Concurrent checks on the sequencer core's ports
`timescale 1ns/10ps
module iss_core_props
   import iss_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   input wire logic [11:0] fetch_addr_out,
   input wire logic fetch_strobe_out,
   input wire iss_flow_t flow_op_in,
   input wire logic [11:0] flow_target_in,
   input wire logic skip_cond_in,
   input wire logic [11:0] int_vector_in,
   input wire logic int_ack_out,
   input wire logic [3:0] phase_out,
   input wire logic dummy_out,
   input wire logic [2:0] stack_level_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // Instruction executes at the edge closing phase four
   logic ex;
   assign ex = phase_out == 4'h8 && !dummy_out;
   a_phase_rotate:
      assert property (phase_out != 4'h0 |=> phase_out ==
         {$past(phase_out[2:0]), $past(phase_out[3])})
      else $error("phase sequence broken");
   a_fetch_phase:
      assert property (fetch_strobe_out == (phase_out == 4'h1))
      else $error("fetch strobe outside phase one");
   a_seq_incr:
      assert property (ex && flow_op_in == ISS_FL_SEQ |=> dummy_out ||
         fetch_addr_out == $past(fetch_addr_out) + 12'h1)
      else $error("sequential step not plus one");
   a_jump_target:
      assert property (ex && flow_op_in == ISS_FL_JUMP |=>
         fetch_addr_out == $past(flow_target_in) && dummy_out)
      else $error("jump target or dummy wrong");
   a_skip_dummy:
      assert property (ex && flow_op_in == ISS_FL_SKIP && skip_cond_in |=>
         dummy_out && fetch_addr_out == $past(fetch_addr_out) + 12'h1)
      else $error("taken skip wrong");
   a_dummy_whole:
      assert property ($rose(dummy_out) |-> phase_out == 4'h1
         ##1 dummy_out [*3])
      else $error("dummy cycle not whole");
   a_call_push:
      assert property (ex && flow_op_in == ISS_FL_CALL |=> stack_level_out ==
         ($past(stack_level_out) == 3'h4 ? 3'h4 : $past(stack_level_out) + 3'h1))
      else $error("call stack level wrong");
   a_ret_pop:
      assert property (ex && flow_op_in == ISS_FL_RET && stack_level_out != 0
         |=> stack_level_out == $past(stack_level_out) - 3'h1 && dummy_out)
      else $error("return stack level wrong");
   a_int_held:
      assert property (stack_level_out == 3'h4 |=> !int_ack_out)
      else $error("interrupt taken with full stack");
   a_int_entry:
      assert property ($rose(int_ack_out) |-> fetch_addr_out == int_vector_in
         && stack_level_out == $past(stack_level_out) + 3'h1)
      else $error("interrupt entry wrong");
   a_reset_start:
      assert property ($fell(reset_in) |-> fetch_addr_out == 12'h0 &&
         stack_level_out == 3'h0)
      else $error("reset start state wrong");
   c_full_call: cover property (ex && flow_op_in == ISS_FL_CALL &&
      stack_level_out == 3'h4);
   c_int_ack: cover property ($rose(int_ack_out));
   c_low_write: cover property (avs_write_in && !avs_waitrequest_out &&
      avs_address_in == ISS_OFF_PCL);
endmodule
bind iss_core iss_core_props u_iss_core_props (
   .clk_in(clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
   .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
   .fetch_addr_out(fetch_addr_out), .fetch_strobe_out(fetch_strobe_out),
   .flow_op_in(flow_op_in), .flow_target_in(flow_target_in),
   .skip_cond_in(skip_cond_in), .int_vector_in(int_vector_in),
   .int_ack_out(int_ack_out), .phase_out(phase_out), .dummy_out(dummy_out),
   .stack_level_out(stack_level_out)
);

// [instruction_sequencer_stack_test.sv]
// Self-checking bench for the instruction sequencer core
`timescale 1ns/10ps
module instruction_sequencer_stack_test;
   import iss_pkg::*;
   logic clk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [3:0] avs_address_in, avs_byteenable_in, phase_out, status_out;
   logic [31:0] avs_writedata_in, avs_readdata_out, rd;
   logic [11:0] fetch_addr_out, flow_target_in, int_vector_in, pc_m;
   logic [15:0] fetch_word_in, instr_out;
   logic fetch_strobe_out, skip_cond_in, ret_from_int_in, alu_to_mem_in;
   logic int_req_in, int_ack_out, dummy_out, mem_write_out;
   logic [7:0] alu_operand_in, mem_result_out, acc_out;
   logic [2:0] stack_level_out;
   iss_flow_t flow_op_in;
   iss_alop_t alu_op_in;
   logic [11:0] saved [0:4];
   int num_errors, comparisons, ack_cnt;
   localparam logic [3:0] AOP [0:9] = '{4'h1, 4'h1, 4'h8, 4'h7, 4'he, 4'hf,
      4'h6, 4'h9, 4'hc, 4'ha};
   localparam logic [7:0] AOPD [0:9] = '{8'hf0, 8'h20, 8'hff, 8'h10, 8'hff,
      8'h00, 8'h0f, 8'h0f, 8'hf0, 8'he1};
   localparam logic [7:0] AEXP [0:9] = '{8'hf0, 8'h10, 8'hef, 8'hff, 8'h00,
      8'hff, 8'h0f, 8'hf0, 8'he1, 8'hf0};
   iss_core u_iss_core (.clk_in(clk_in), .reset_in(reset_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .fetch_addr_out(fetch_addr_out), .fetch_strobe_out(fetch_strobe_out),
      .fetch_word_in(fetch_word_in), .flow_op_in(flow_op_in),
      .flow_target_in(flow_target_in), .skip_cond_in(skip_cond_in),
      .ret_from_int_in(ret_from_int_in), .alu_op_in(alu_op_in),
      .alu_operand_in(alu_operand_in), .alu_to_mem_in(alu_to_mem_in),
      .int_req_in(int_req_in), .int_vector_in(int_vector_in),
      .int_ack_out(int_ack_out), .instr_out(instr_out),
      .phase_out(phase_out), .dummy_out(dummy_out),
      .mem_result_out(mem_result_out), .mem_write_out(mem_write_out),
      .status_out(status_out), .acc_out(acc_out),
      .stack_level_out(stack_level_out));
   iss_prog_mem u_iss_prog_mem (.clk_in(clk_in), .strobe_in(fetch_strobe_out),
      .addr_in(fetch_addr_out), .word_out(fetch_word_in));
   // 20 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // Count interrupt acknowledge pulses
   always @(posedge clk_in) begin
      if (int_ack_out === 1'b1) ack_cnt <= ack_cnt + 1;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One bus access; holds until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   // Present one decoded instruction across phase four, check the result
   task automatic step(input iss_flow_t f, input logic [11:0] t,
      input logic sk, input logic [3:0] op, input logic [7:0] opd,
      input logic [11:0] nxt, input logic dum);
      @(posedge clk_in);
      while (phase_out !== ISS_PH3) @(posedge clk_in);
      chk(instr_out, {4'ha, pc_m});
      flow_op_in <= f;
      flow_target_in <= t;
      skip_cond_in <= sk;
      alu_op_in <= iss_alop_t'(op);
      alu_operand_in <= opd;
      @(posedge clk_in);
      flow_op_in <= ISS_FL_SEQ;
      skip_cond_in <= 1'b0;
      alu_op_in <= ISS_AL_NONE;
      @(posedge clk_in);
      chk(fetch_addr_out, nxt);
      chk(dummy_out, dum);
      pc_m = nxt;
   endtask
   task automatic seq(input logic [11:0] nxt, input logic dum);
      step(ISS_FL_SEQ, 12'h0, 1'b0, 4'h0, 8'h00, nxt, dum);
   endtask
   task automatic test_done;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      num_errors++;
      test_done;
   end
   initial begin
      {avs_read_in, avs_write_in, skip_cond_in, ret_from_int_in} = 4'h0;
      {alu_to_mem_in, int_req_in} = 2'h0;
      avs_address_in = 4'h0;
      avs_byteenable_in = 4'hf;
      avs_writedata_in = 32'h0;
      flow_op_in = ISS_FL_SEQ;
      flow_target_in = 12'h0;
      alu_op_in = ISS_AL_NONE;
      alu_operand_in = 8'h00;
      int_vector_in = 12'h0a0;
      {num_errors, comparisons, ack_cnt} = '0;
      pc_m = 12'h000;
      reset_in = 1'b1;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      chk(fetch_addr_out, 32'h0);
      chk(stack_level_out, 32'h0);
      seq(12'h001, 1'b0);
      $display("reset test done");
      seq(12'h002, 1'b0);
      step(ISS_FL_SKIP, 12'h0, 1'b0, 4'h0, 8'h00, 12'h003, 1'b0);
      step(ISS_FL_SKIP, 12'h0, 1'b1, 4'h0, 8'h00, 12'h004, 1'b1);
      step(ISS_FL_JUMP, 12'h0, 1'b0, 4'h0, 8'h00, 12'h005, 1'b0);
      step(ISS_FL_JUMP, 12'h345, 1'b0, 4'h0, 8'h00, 12'h345, 1'b1);
      seq(12'h346, 1'b0);
      $display("flow test done");
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, ISS_OFF_PCL, 32'h12);
      @(posedge clk_in);
      while (phase_out !== ISS_PH4) @(posedge clk_in);
      @(posedge clk_in);
      chk(fetch_addr_out, 32'h312);
      chk(dummy_out, 32'h1);
      bus(1'b0, ISS_OFF_PCL, 32'h0);
      chk(rd, 32'h12);
      @(posedge clk_in);
      chk(fetch_addr_out, 32'h313);
      pc_m = 12'h313;
      $display("low byte test done");
      for (int i = 0; i < 5; i++) begin
         saved[i] = pc_m;
         step(ISS_FL_CALL, 12'h100 * (i + 1), 1'b0, 4'h0, 8'h00,
            12'h100 * (i + 1), 1'b1);
         seq(12'h100 * (i + 1) + 12'h1, 1'b0);
         chk(stack_level_out, (i < 4) ? i + 1 : 4);
      end
      int_req_in <= 1'b1;
      @(posedge clk_in);
      int_req_in <= 1'b0;
      seq(pc_m + 12'h1, 1'b0);
      chk(ack_cnt, 32'h0);
      step(ISS_FL_RET, 12'h0, 1'b0, 4'h0, 8'h00, saved[4], 1'b1);
      seq(12'h0a0, 1'b1);
      chk(stack_level_out, 32'h4);
      seq(12'h0a1, 1'b0);
      chk(ack_cnt, 32'h1);
      ret_from_int_in <= 1'b1;
      step(ISS_FL_RET, 12'h0, 1'b0, 4'h0, 8'h00, saved[4], 1'b1);
      ret_from_int_in <= 1'b0;
      seq(saved[4] + 12'h1, 1'b0);
      for (int i = 3; i > 0; i--) begin
         step(ISS_FL_RET, 12'h0, 1'b0, 4'h0, 8'h00, saved[i], 1'b1);
         seq(saved[i] + 12'h1, 1'b0);
      end
      chk(stack_level_out, 32'h0);
      $display("stack test done");
      for (int i = 0; i < 10; i++) begin
         step(ISS_FL_SEQ, 12'h0, 1'b0, AOP[i], AOPD[i], pc_m + 12'h1, 1'b0);
         chk(acc_out, AEXP[i]);
         if (i == 1) chk(status_out[ISS_ST_C], 32'h1);
         if (i == 4) chk(status_out[ISS_ST_Z], 32'h1);
      end
      $display("arithmetic test done");
      test_done;
   end
endmodule
